// file: include/vis_defines.svh
// Constants of the vectored interrupt status register set.
// Assumes a 32-bit word bus with byte offsets as printed.
`ifndef VIS_DEFINES_SVH
`define VIS_DEFINES_SVH

`define VIS_OFF_HANDLER_BASE  12'h080
`define VIS_OFF_HANDLER_LAST  12'h0FC
`define VIS_OFF_NORMAL_VEC    12'h100
`define VIS_OFF_FAST_VEC      12'h104
`define VIS_OFF_STATUS        12'h108
`define VIS_OFF_PENDING       12'h10C
`define VIS_OFF_MASK          12'h110
`define VIS_OFF_ENABLE_CMD    12'h120
`define VIS_OFF_DISABLE_CMD   12'h124
`define VIS_OFF_NORMAL_WR     12'h100
`define VIS_OFF_END_CMD       12'h130
`define VIS_OFF_IRQ_STATUS    12'h140
`define VIS_OFF_IRQ_MASK      12'h144
`define VIS_OFF_PROTECT       12'h148

`define VIS_SRC_COUNT         32
`define VIS_ID_LSB            0
`define VIS_ID_WIDTH          5
`define VIS_FAST_BIT          0
`define VIS_SOFT_BIT          1
`define VIS_EXT_LSB           28
`define VIS_EXT_COUNT         4
`define VIS_RESET_WORD        32'h0000_0000
`define VIS_RESET_ID          5'h00

`define VIS_EV_ACK            0
`define VIS_EV_END            1
`define VIS_EV_WIDTH          2

`endif

// file: include/vis_pkg.sv
// Types shared by the vectored interrupt status register set.
// Assumes vis_defines.svh is on the include path.
`include "vis_defines.svh"

package vis_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vis_bus_req_t;

  typedef enum logic [2:0] {
    VIS_IDLE    = 3'b001,
    VIS_PEEKED  = 3'b010,
    VIS_SERVING = 3'b100
  } vis_state_t;

endpackage

// file: hw/vis_pick.sv
// Picks the highest numbered enabled pending source above bit 0.
// Assumes pending and mask come from the same clock domain.
`include "vis_defines.svh"

module vis_pick (
  input  wire logic [31:0] pending_in,
  input  wire logic [31:0] mask_in,
  output logic             found_out,
  output logic [4:0]       id_out
);

  logic [31:0] live;

  always_comb begin
    live      = pending_in & mask_in;
    found_out = 1'b0;
    id_out    = `VIS_RESET_ID;
    // Fast source has its own vector; never competes for the normal one
    for (int i = 1; i < `VIS_SRC_COUNT; i++) begin
      if (live[i]) begin
        found_out = 1'b1;
        id_out    = 5'(i);
      end
    end
  end

endmodule

// file: hw/vis_regs.sv
// Vectored interrupt status register set: handler table and vector readout.
// Assumes a single-cycle register port and asynchronous source lines.
// Unmapped offsets read zero; writes to read-only offsets are ignored.
// Event status and mask give software an interrupt on acknowledge and end.
//
// Behaviour
// - 32 read/write handler addresses, reset zero.
// - Normal vector read returns current source's handler.
// - Handler chosen at read by current number 1..31.
// - No current interrupt: normal vector reads zero.
// - Fast vector read returns handler entry zero.
// - Status register gives current source number, reset zero.
// - Pending bit per source; fast bit0, software bit1.
// - Mask bit per source, one enabled, reset zero.
// - Enable/disable command ones set/clear mask bits.
// - External pending bits reset from line levels.
// - Protect mode: only vector write acknowledges.
//
// Implementation choices: strobed register access and the address map.
`include "vis_defines.svh"

module vis_regs (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire vis_pkg::vis_bus_req_t bus_in,
  output logic [31:0]               rdata_out,
  input  wire logic [31:0]          source_in,
  output logic                      irq_out
);

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  logic [31:0] src_meta_reg;
  logic [31:0] src_sync_reg;

  // Lines move at any time; two flops keep metastability out of the pick
  always_ff @(posedge clk_in) begin
    src_meta_reg <= source_in;
    src_sync_reg <= src_meta_reg;
  end

  // ****************************************************************
  // Handler table
  // ****************************************************************
  logic [31:0] handler_reg  [`VIS_SRC_COUNT];
  logic [31:0] handler_next [`VIS_SRC_COUNT];

  // Entry 0 holds the fast handler; the normal vector never indexes it
  function automatic logic is_handler(input logic [11:0] a);
    return (a >= `VIS_OFF_HANDLER_BASE) && (a <= `VIS_OFF_HANDLER_LAST);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Unaligned handler offsets up to 0x0FC alias to the word below; other offsets match exactly; there are no byte lanes
  logic [4:0] wr_index;
  assign wr_index = bus_in.addr[6:2];

  always_comb begin
    for (int i = 0; i < `VIS_SRC_COUNT; i++) begin
      handler_next[i] = handler_reg[i];
    end
    if (bus_in.wr && is_handler(bus_in.addr)) begin
      handler_next[wr_index] = bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < `VIS_SRC_COUNT; i++) begin
      if (!resetn_in) begin
        handler_reg[i] <= `VIS_RESET_WORD;
      end else begin
        handler_reg[i] <= handler_next[i];
      end
    end
  end

  // ****************************************************************
  // Mask, pending, protect
  // ****************************************************************
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] pend_reg;
  logic [31:0] pend_next;
  logic        protect_reg;
  logic        protect_next;
  logic        ext_load_reg;
  logic        ext_load_next;

  always_comb begin
    mask_next     = mask_reg;
    protect_next  = protect_reg;
    ext_load_next = 1'b0;
    // Enable and disable sit at separate offsets, so a write never does both
    if (bus_in.wr && hit(bus_in.addr, `VIS_OFF_ENABLE_CMD)) begin
      mask_next = mask_reg | bus_in.wdata;
    end
    if (bus_in.wr && hit(bus_in.addr, `VIS_OFF_DISABLE_CMD)) begin
      mask_next = mask_reg & ~bus_in.wdata;
    end
    if (bus_in.wr && hit(bus_in.addr, `VIS_OFF_PROTECT)) begin
      protect_next = bus_in.wdata[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mask_reg     <= `VIS_RESET_WORD;
      protect_reg  <= 1'b0;
      ext_load_reg <= 1'b1;
    end else begin
      mask_reg     <= mask_next;
      protect_reg  <= protect_next;
      ext_load_reg <= ext_load_next;
    end
  end

  // External bits load from the lines right after reset release
  always_comb begin
    // Pending follows the synchronised lines; an acknowledge does not latch
    pend_next = src_sync_reg;
    if (ext_load_reg) begin
      pend_next = src_sync_reg & {{`VIS_EXT_COUNT{1'b1}}, 28'h0000000};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pend_reg <= `VIS_RESET_WORD;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ****************************************************************
  // Current source tracking
  // ****************************************************************
  logic                found;
  logic [4:0]          pick_id;
  vis_pkg::vis_state_t state_reg;
  vis_pkg::vis_state_t state_next;
  logic [4:0]          cur_reg;
  logic [4:0]          cur_next;
  logic [4:0]          peek_reg;
  logic [4:0]          peek_next;
  logic [`VIS_EV_WIDTH-1:0] ev;

  vis_pick u_pick (
    .pending_in (pend_reg),
    .mask_in    (mask_reg),
    .found_out  (found),
    .id_out     (pick_id)
  );

  // A normal-mode vector read is the acknowledge; a debugger sets protect first
  logic rd_vec;
  logic wr_vec;
  logic wr_end;
  assign rd_vec = bus_in.rd && hit(bus_in.addr, `VIS_OFF_NORMAL_VEC);
  assign wr_vec = bus_in.wr && hit(bus_in.addr, `VIS_OFF_NORMAL_WR);
  assign wr_end = bus_in.wr && hit(bus_in.addr, `VIS_OFF_END_CMD);

  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    peek_next  = peek_reg;
    ev         = '0;
    unique case (state_reg)
      vis_pkg::VIS_IDLE: begin
        if (rd_vec && found) begin
          if (protect_reg) begin
            peek_next  = pick_id;
            state_next = vis_pkg::VIS_PEEKED;
          end else begin
            cur_next   = pick_id;
            state_next = vis_pkg::VIS_SERVING;
            ev[`VIS_EV_ACK] = 1'b1;
          end
        end
      end
      // A peek lasts until the vector write or until protect is turned off
      vis_pkg::VIS_PEEKED: begin
        if (wr_vec) begin
          cur_next   = peek_reg;
          state_next = vis_pkg::VIS_SERVING;
          ev[`VIS_EV_ACK] = 1'b1;
        end else if (!protect_reg) begin
          state_next = vis_pkg::VIS_IDLE;
        end
      end
      vis_pkg::VIS_SERVING: begin
        if (wr_end) begin
          cur_next   = `VIS_RESET_ID;
          state_next = vis_pkg::VIS_IDLE;
          ev[`VIS_EV_END] = 1'b1;
        end
      end
      default: begin
        state_next = vis_pkg::VIS_IDLE;
        cur_next   = `VIS_RESET_ID;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= vis_pkg::VIS_IDLE;
      cur_reg   <= `VIS_RESET_ID;
      peek_reg  <= `VIS_RESET_ID;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      peek_reg  <= peek_next;
    end
  end

  // ****************************************************************
  // Event interrupt
  // ****************************************************************
  logic [`VIS_EV_WIDTH-1:0] evst_reg;
  logic [`VIS_EV_WIDTH-1:0] evst_next;
  logic [`VIS_EV_WIDTH-1:0] evmask_reg;
  logic [`VIS_EV_WIDTH-1:0] evmask_next;

  always_comb begin
    evst_next   = evst_reg;
    evmask_next = evmask_reg;
    if (bus_in.wr && hit(bus_in.addr, `VIS_OFF_IRQ_STATUS)) begin
      evst_next = evst_reg & ~bus_in.wdata[`VIS_EV_WIDTH-1:0];
    end
    if (bus_in.wr && hit(bus_in.addr, `VIS_OFF_IRQ_MASK)) begin
      evmask_next = bus_in.wdata[`VIS_EV_WIDTH-1:0];
    end
    // Set beats clear in the same cycle
    evst_next = evst_next | ev;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      evst_reg   <= '0;
      evmask_reg <= '0;
    end else begin
      evst_reg   <= evst_next;
      evmask_reg <= evmask_next;
    end
  end

  // Level output; stays high until software clears or masks the event
  assign irq_out = |(evst_reg & evmask_reg);

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic        serving;
  logic [4:0]  vec_id;

  always_comb begin
    serving = (state_reg == vis_pkg::VIS_SERVING);
    // Normal mode acknowledges on this read, so index by the picked source
    vec_id  = serving ? cur_reg : pick_id;
    // Reserved and write-only offsets read zero
    rdata_next = `VIS_RESET_WORD;
    if (bus_in.rd) begin
      if (is_handler(bus_in.addr)) begin
        rdata_next = handler_reg[bus_in.addr[6:2]];
      end else if (hit(bus_in.addr, `VIS_OFF_NORMAL_VEC)) begin
        if (serving || found) begin
          rdata_next = handler_reg[vec_id];
        end else begin
          rdata_next = `VIS_RESET_WORD;
        end
      end else if (hit(bus_in.addr, `VIS_OFF_FAST_VEC)) begin
        rdata_next = handler_reg[`VIS_FAST_BIT];
      end else if (hit(bus_in.addr, `VIS_OFF_STATUS)) begin
        rdata_next = {27'h0000000, cur_reg};
      end else if (hit(bus_in.addr, `VIS_OFF_PENDING)) begin
        rdata_next = pend_reg;
      end else if (hit(bus_in.addr, `VIS_OFF_MASK)) begin
        rdata_next = mask_reg;
      end else if (hit(bus_in.addr, `VIS_OFF_IRQ_STATUS)) begin
        rdata_next = {30'h00000000, evst_reg};
      end else if (hit(bus_in.addr, `VIS_OFF_IRQ_MASK)) begin
        rdata_next = {30'h00000000, evmask_reg};
      end else if (hit(bus_in.addr, `VIS_OFF_PROTECT)) begin
        rdata_next = {31'h00000000, protect_reg};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_reg <= `VIS_RESET_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

endmodule

// file: test/vis_regs_assertions.sv
// Checker for the vectored interrupt register set.
// Assumes it is bound to vis_regs and sees only its ports.
`include "vis_defines.svh"
module vis_regs_assertions (
  input wire logic                  clk_in,
  input wire logic                  resetn_in,
  input wire vis_pkg::vis_bus_req_t bus_in,
  input wire logic [31:0]           rdata_out,
  input wire logic [31:0]           source_in,
  input wire logic                  irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] h0_reg;
  logic [31:0] h31_reg;
  logic [31:0] m_reg;
  logic        ack_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Shadows of what software wrote, so readouts can be judged
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      h0_reg  <= 32'h0000_0000;
      h31_reg <= 32'h0000_0000;
      m_reg   <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      // Any vector access may start service; only end of interrupt finishes it
      if (bus_in.addr == `VIS_OFF_NORMAL_VEC && (bus_in.rd || bus_in.wr)) ack_reg <= 1'b1;
      if (bus_in.wr && bus_in.addr == `VIS_OFF_END_CMD) ack_reg <= 1'b0;
      if (bus_in.wr && bus_in.addr == `VIS_OFF_HANDLER_BASE) h0_reg <= bus_in.wdata;
      if (bus_in.wr && bus_in.addr == `VIS_OFF_HANDLER_LAST) h31_reg <= bus_in.wdata;
      if (bus_in.wr && bus_in.addr == `VIS_OFF_ENABLE_CMD) m_reg <= m_reg | bus_in.wdata;
      if (bus_in.wr && bus_in.addr == `VIS_OFF_DISABLE_CMD) m_reg <= m_reg & ~bus_in.wdata;
    end
  end
  fast_vec_entry_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_FAST_VEC |=> rdata_out == $past(h0_reg))
    else $error("fast vector differs from handler zero");
  handler_first_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_HANDLER_BASE |=> rdata_out == $past(h0_reg))
    else $error("handler zero readback wrong");
  handler_last_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_HANDLER_LAST |=> rdata_out == $past(h31_reg))
    else $error("handler 31 readback wrong");
  mask_readout_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_MASK |=> rdata_out == $past(m_reg))
    else $error("mask readout wrong");
  normal_vec_zero_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_NORMAL_VEC && m_reg[31:1] == 31'h0 && !ack_reg
    |=> rdata_out == 32'h0000_0000) else $error("normal vector not zero");
  status_high_zero_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_STATUS |=> rdata_out[31:5] == 27'h0)
    else $error("status upper bits set");
  status_id_reset_a: assert property (
    bus_in.rd && bus_in.addr == `VIS_OFF_STATUS && !ack_reg |=> rdata_out == 32'h0000_0000)
    else $error("status id not zero before any vector");
  pending_follow_a: assert property (
    ($stable(source_in) && resetn_in)[*5] ##0 (bus_in.rd && bus_in.addr == `VIS_OFF_PENDING)
    |=> rdata_out == $past(source_in)) else $error("pending differs from lines");
endmodule

bind vis_regs vis_regs_assertions i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .source_in(source_in), .irq_out(irq_out));

// file: test/vis_src_model.sv
// Model of the interrupt source lines feeding the register set.
// Assumes the bench sets the wanted levels; lines move only after edges.
module vis_src_model (
  input  wire logic [31:0] level_in,
  input  wire logic        clk_in,
  output logic [31:0]      source_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] line_reg = 32'h0000_0000;
  // Registered so a line changes only on the design's rising edge, after the design has sampled it
  always @(posedge clk_in) line_reg <= level_in;
  assign source_out = line_reg;
endmodule

// file: test/vectored_interrupt_status_regs_tb_top.sv
// Self-checking bench for the vectored interrupt register set.
// Assumes one 40 MHz clock and the source line model beside the design.
`include "vis_defines.svh"
module vectored_interrupt_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_in = 1'b0;
  logic                  resetn_in = 1'b0;
  vis_pkg::vis_bus_req_t bus_in = '0;
  logic [31:0]           line_level = 32'h1000_0000;
  logic [31:0]           source_in;
  logic [31:0]           rdata_out;
  logic                  irq_out;
  int                    n_mismatch = 0;
  int                    num_checks = 0;
  always #12.5 clk_in = ~clk_in;
  vis_src_model i_src (.level_in(line_level), .clk_in(clk_in), .source_out(source_in));
  vis_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .source_in(source_in), .irq_out(irq_out));
  function automatic logic [31:0] hv(input int i);
    return {8'hA5, 19'h0, 5'(i)};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in <= '0;
    #1;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    #1 check($sformatf("reg %h", a), rdata_out, exp);
  endtask
  task automatic t_reset();
    rc(`VIS_OFF_STATUS, 32'h0000_0000);
    rc(`VIS_OFF_MASK, 32'h0000_0000);
    rc(`VIS_OFF_NORMAL_VEC, 32'h0000_0000);
    rc(`VIS_OFF_HANDLER_BASE + 12'h014, 32'h0000_0000);
    rc(12'h118, 32'h0000_0000);
    rc(`VIS_OFF_PENDING, 32'h1000_0000);
  endtask
  task automatic t_handlers();
    for (int i = 0; i < 32; i++) wr(`VIS_OFF_HANDLER_BASE + 12'(4 * i), hv(i));
    for (int i = 0; i < 32; i++) rc(`VIS_OFF_HANDLER_BASE + 12'(4 * i), hv(i));
    rc(`VIS_OFF_FAST_VEC, hv(0));
  endtask
  task automatic t_pending_mask();
    line_level <= 32'h1000_0803;
    wr(`VIS_OFF_PENDING, 32'hFFFF_FFFF);
    repeat (5) @(posedge clk_in);
    rc(`VIS_OFF_PENDING, 32'h1000_0803);
    wr(`VIS_OFF_ENABLE_CMD, 32'h0000_0F0D);
    wr(`VIS_OFF_DISABLE_CMD, 32'h0000_0104);
    rc(`VIS_OFF_MASK, 32'h0000_0E09);
  endtask
  task automatic t_vector();
    rc(`VIS_OFF_NORMAL_VEC, hv(11));
    rc(`VIS_OFF_STATUS, 32'h0000_000B);
    wr(`VIS_OFF_END_CMD, 32'h0000_0000);
    rc(`VIS_OFF_STATUS, 32'h0000_0000);
    wr(`VIS_OFF_DISABLE_CMD, 32'hFFFF_FFFE);
    rc(`VIS_OFF_NORMAL_VEC, 32'h0000_0000);
  endtask
  task automatic t_protect();
    wr(`VIS_OFF_PROTECT, 32'h0000_0001);
    wr(`VIS_OFF_ENABLE_CMD, 32'h0000_0800);
    rc(`VIS_OFF_NORMAL_VEC, hv(11));
    rc(`VIS_OFF_STATUS, 32'h0000_0000);
    wr(`VIS_OFF_NORMAL_WR, 32'h0000_0000);
    rc(`VIS_OFF_STATUS, 32'h0000_000B);
    wr(`VIS_OFF_END_CMD, 32'h0000_0000);
    wr(`VIS_OFF_PROTECT, 32'h0000_0000);
  endtask
  task automatic t_irq();
    wr(`VIS_OFF_IRQ_STATUS, 32'h0000_0003);
    wr(`VIS_OFF_IRQ_MASK, 32'h0000_0001);
    check("irq idle", {31'h0, irq_out}, 32'h0000_0000);
    rc(`VIS_OFF_NORMAL_VEC, hv(11));
    @(posedge clk_in);
    #1 check("irq ack", {31'h0, irq_out}, 32'h0000_0001);
    wr(`VIS_OFF_IRQ_MASK, 32'h0000_0000);
    check("irq masked", {31'h0, irq_out}, 32'h0000_0000);
    wr(`VIS_OFF_IRQ_MASK, 32'h0000_0001);
    check("irq unmasked", {31'h0, irq_out}, 32'h0000_0001);
    wr(`VIS_OFF_IRQ_STATUS, 32'h0000_0001);
    check("irq cleared", {31'h0, irq_out}, 32'h0000_0000);
  endtask
  task automatic t_rereset();
    @(posedge clk_in);
    line_level <= 32'h3000_0002;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rc(`VIS_OFF_PENDING, 32'h3000_0000);
    rc(`VIS_OFF_PENDING, 32'h3000_0002);
    rc(`VIS_OFF_HANDLER_LAST, 32'h0000_0000);
    rc(`VIS_OFF_MASK, 32'h0000_0000);
    rc(`VIS_OFF_STATUS, 32'h0000_0000);
    check("irq after reset", {31'h0, irq_out}, 32'h0000_0000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_handlers();
    t_pending_mask();
    t_vector();
    t_protect();
    t_irq();
    t_rereset();
    conclude();
  end
  // Run needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    n_mismatch++;
    conclude();
  end
endmodule
